// ---- rtl/aiwc_beat.sv ----
`timescale 1ns/1ps
`include "aiwc_map.svh"
// square wave with a programmable half period
module aiwc_beat #(
	parameter int HALF_CYCLES = `AIWC_HALF_CYCLES
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// control and output
	input wire logic run_i,
	output logic beat_o
);
	localparam int CW = $clog2(HALF_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic next_beat;

	// stopped beat parks low so a fault shows as a dead line
	always_comb begin
		next_count = count;
		next_beat = beat_o;
		if (!run_i) begin
			next_count = '0;
			next_beat = 1'b0;
		end else if (count == LAST) begin
			next_count = '0;
			next_beat = !beat_o;
		end else begin
			next_count = count + CW'(1);
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count <= '0;
			beat_o <= 1'b0;
		end else begin
			count <= next_count;
			beat_o <= next_beat;
		end
	end

	// each level lasts exactly one half period
	half_period_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		run_i && $past(run_i) && $changed(beat_o) |-> count == '0)
		else $error("heartbeat edge off its count");
endmodule

// ---- rtl/aiwc_map.svh ----
`ifndef AIWC_MAP_SVH
`define AIWC_MAP_SVH

// command word bit positions
`define AIWC_CMD_HBUSY 0
`define AIWC_CMD_HWDONE 1
`define AIWC_CMD_HRDONE 2
`define AIWC_CMD_SAVE 3
`define AIWC_CMD_SERWEN 4
`define AIWC_CMD_ALMCLR 5
`define AIWC_CMD_RNGCLR 6
`define AIWC_CMD_BANK 7
`define AIWC_CMD_PKLO 8
// status word bit positions
`define AIWC_ST_BUSY 0
`define AIWC_ST_RDONE 1
`define AIWC_ST_WDONE 2
`define AIWC_ST_BADDATA 3
`define AIWC_ST_CONVERR 4
`define AIWC_ST_ALARM 5
`define AIWC_ST_RANGE 6
`define AIWC_ST_GOOD 7
`define AIWC_ST_ACKLO 8
// reset values
`define AIWC_STATUS_RST 16'h0000
// heartbeat half period
`define AIWC_CLK_HZ 50000000
`define AIWC_HALF_PERIOD_MS 500
`define AIWC_HALF_CYCLES (`AIWC_CLK_HZ / 1000 * `AIWC_HALF_PERIOD_MS)
`endif

// ---- rtl/aiwc_pkg.sv ----
package aiwc_pkg;
	// word handed to the unit by the host
	typedef struct packed {
		logic [7:0] pk_reset;
		logic bank_hi;
		logic range_clr;
		logic alarm_clr;
		logic serial_wen;
		logic save_req;
		logic host_read_done;
		logic host_write_done;
		logic host_xfer_active;
	} aiwc_cmd_t;
	// word returned to the host
	typedef struct packed {
		logic [7:0] pk_ack;
		logic good;
		logic range_flag;
		logic alarm_flag;
		logic conv_err;
		logic bad_data;
		logic write_done;
		logic read_done;
		logic busy;
	} aiwc_status_t;
	// transfer handshake states
	typedef enum logic [3:0] {
		AIWC_IDLE = 4'h1,
		AIWC_BUSY = 4'h2,
		AIWC_RDONE = 4'h4,
		AIWC_WDONE = 4'h8
	} aiwc_xfer_t;
endpackage

// ---- rtl/aiwc_top.sv ----
`timescale 1ns/1ps
`include "aiwc_map.svh"
// command/status word logic of the analog input unit
module aiwc_top #(
	parameter int HALF_CYCLES = `AIWC_HALF_CYCLES
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// backplane words
	input wire aiwc_pkg::aiwc_cmd_t cmd_i,
	input wire logic xfer_start_i,
	input wire logic xfer_is_write_i,
	input wire logic xfer_end_i,
	output aiwc_pkg::aiwc_status_t status_o,
	// unit-side events
	input wire logic data_invalid_i,
	input wire logic data_valid_i,
	input wire logic conv_err_i,
	input wire logic any_alarm_i,
	input wire logic any_range_i,
	input wire logic unit_ok_i,
	input wire logic pk_done_i,
	// unit-side commands
	output logic save_req_o,
	output logic serial_wen_o,
	output logic [15:0] pk_clear_o
);
	aiwc_pkg::aiwc_xfer_t xfer;
	aiwc_pkg::aiwc_xfer_t next_xfer;
	logic xfer_wr;
	logic next_xfer_wr;
	aiwc_pkg::aiwc_status_t next_status;
	logic save_prev;
	logic next_save_req;
	logic next_serial_wen;
	logic [15:0] next_pk_clear;
	logic [15:0] pk_req;
	logic beat;

	aiwc_beat #(.HALF_CYCLES(HALF_CYCLES)) u_beat (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.run_i(unit_ok_i),
		.beat_o(beat)
	);

	// requested peak-hold points spread over the chosen bank
	always_comb begin
		pk_req = cmd_i.bank_hi ? {cmd_i.pk_reset, 8'h00} : {8'h00, cmd_i.pk_reset};
	end

	// handshake bits come from transfer state, never from host move data
	always_comb begin
		next_xfer = xfer;
		next_xfer_wr = xfer_wr;
		unique case (xfer)
			aiwc_pkg::AIWC_IDLE: begin
				if (xfer_start_i) begin
					next_xfer = aiwc_pkg::AIWC_BUSY;
					next_xfer_wr = xfer_is_write_i;
				end
			end
			aiwc_pkg::AIWC_BUSY: begin
				if (xfer_end_i) begin
					next_xfer = xfer_wr ? aiwc_pkg::AIWC_WDONE : aiwc_pkg::AIWC_RDONE;
				end
			end
			aiwc_pkg::AIWC_RDONE, aiwc_pkg::AIWC_WDONE: begin
				next_xfer = aiwc_pkg::AIWC_IDLE;
			end
			default: begin
				next_xfer = aiwc_pkg::AIWC_IDLE;
			end
		endcase
	end

	// status word; hardware set wins over host clear
	always_comb begin
		next_status = status_o;
		next_status.busy = (next_xfer == aiwc_pkg::AIWC_BUSY);
		next_status.read_done = (next_xfer == aiwc_pkg::AIWC_RDONE);
		next_status.write_done = (next_xfer == aiwc_pkg::AIWC_WDONE);
		if (data_invalid_i) begin
			next_status.bad_data = 1'b1;
		end else if (data_valid_i) begin
			next_status.bad_data = 1'b0;
		end
		next_status.conv_err = conv_err_i;
		if (any_alarm_i) begin
			next_status.alarm_flag = 1'b1;
		end else if (cmd_i.alarm_clr) begin
			next_status.alarm_flag = 1'b0;
		end
		if (any_range_i) begin
			next_status.range_flag = 1'b1;
		end else if (cmd_i.range_clr) begin
			next_status.range_flag = 1'b0;
		end
		next_status.good = beat;
		// ack follows request once the engine has cleared it
		next_status.pk_ack = cmd_i.pk_reset & (status_o.pk_ack | {8{pk_done_i}});
	end

	// control outputs toward the unit core
	always_comb begin
		next_save_req = cmd_i.save_req && !save_prev;
		next_serial_wen = cmd_i.serial_wen;
		next_pk_clear = pk_req & ~({16{1'b0}} | (cmd_i.bank_hi ? {status_o.pk_ack, 8'h00}
			: {8'h00, status_o.pk_ack}));
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			xfer <= aiwc_pkg::AIWC_IDLE;
			xfer_wr <= 1'b0;
			status_o <= `AIWC_STATUS_RST;
			save_prev <= 1'b0;
			save_req_o <= 1'b0;
			serial_wen_o <= 1'b0;
			pk_clear_o <= 16'h0000;
		end else begin
			xfer <= next_xfer;
			xfer_wr <= next_xfer_wr;
			status_o <= next_status;
			save_prev <= cmd_i.save_req;
			save_req_o <= next_save_req;
			serial_wen_o <= next_serial_wen;
			pk_clear_o <= next_pk_clear;
		end
	end

	// one save pulse per rising request edge
	save_pulse_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$rose(cmd_i.save_req) |=> save_req_o ##1 !save_req_o)
		else $error("save request not a single pulse");
	serial_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		1'b1 |=> serial_wen_o == $past(cmd_i.serial_wen))
		else $error("serial write enable not following host");
	alarm_clear_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		cmd_i.alarm_clr && !any_alarm_i |=> !status_o.alarm_flag)
		else $error("alarm flag not cleared");
	range_clear_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		cmd_i.range_clr && !any_range_i |=> !status_o.range_flag)
		else $error("range flag not cleared");
	bank_route_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		cmd_i.bank_hi |=> pk_clear_o[7:0] == 8'h00)
		else $error("low bank touched while high bank chosen");
	xfer_flags_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		status_o.busy && xfer_end_i |=> !status_o.busy && (status_o.read_done ^ status_o.write_done) ##1
		!status_o.read_done && !status_o.write_done)
		else $error("transfer handshake out of step");
	bad_data_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		data_invalid_i |=> status_o.bad_data)
		else $error("invalid data not flagged");
	conv_err_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		conv_err_i |=> status_o.conv_err)
		else $error("conversion error not flagged");
	alarm_sticky_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		status_o.alarm_flag && !cmd_i.alarm_clr |=> status_o.alarm_flag)
		else $error("alarm flag dropped without clear");
	range_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		any_range_i |=> status_o.range_flag)
		else $error("range flag not set");
	ack_release_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		status_o.pk_ack[0] && !cmd_i.pk_reset[0] |=> !status_o.pk_ack[0])
		else $error("ack held after request dropped");
	ack_cause_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$rose(status_o.pk_ack[0]) |-> $past(pk_done_i) && $past(cmd_i.pk_reset[0]))
		else $error("ack without completed reset");

	// summary flags: alarm, range and bad data set by events and held until the matching clear; conversion error follows its input
	alarm_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		any_alarm_i |=> status_o.alarm_flag)
		else $error("alarm flag not set");
	range_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		status_o.range_flag && !cmd_i.range_clr |=> status_o.range_flag)
		else $error("range flag dropped without clear");
	bad_clear_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		data_valid_i && !data_invalid_i |=> !status_o.bad_data)
		else $error("invalid data flag not cleared by valid data");
	conv_follow_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!conv_err_i |=> !status_o.conv_err)
		else $error("conversion error flag without an error");

	// transfer handshake: start taken only from idle, done lasts one cycle
	busy_start_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		xfer == aiwc_pkg::AIWC_IDLE && xfer_start_i |=> status_o.busy)
		else $error("transfer start not shown as busy");
	read_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		status_o.busy && xfer_end_i && !xfer_wr |=> status_o.read_done)
		else $error("block read end not flagged");
	write_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		status_o.busy && xfer_end_i && xfer_wr |=> status_o.write_done)
		else $error("block write end not flagged");
	done_quiet_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		status_o.read_done || status_o.write_done |=> !status_o.busy)
		else $error("start accepted during done cycle");

	// peak-hold clear requests and their release
	low_bank_only_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!cmd_i.bank_hi |=> pk_clear_o[15:8] == 8'h00)
		else $error("high bank touched while low bank chosen");
	clear_first_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!cmd_i.bank_hi && cmd_i.pk_reset[0] && !status_o.pk_ack[0] |=> pk_clear_o[0])
		else $error("point one clear not requested");
	clear_last_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		cmd_i.bank_hi && cmd_i.pk_reset[7] && !status_o.pk_ack[7] |=> pk_clear_o[15])
		else $error("point sixteen clear not requested");
	clear_drop_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!cmd_i.pk_reset[0] |=> !pk_clear_o[0] && !pk_clear_o[8])
		else $error("clear request outlives host bit");
	ack_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		cmd_i.pk_reset[0] && pk_done_i |=> status_o.pk_ack[0])
		else $error("completed reset not acknowledged");

	// an unhealthy unit shows a dead heartbeat after the output stage
	beat_dead_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!unit_ok_i |-> ##2 !status_o.good)
		else $error("heartbeat running while unit not ok");
endmodule

// ---- sim/aiwc_host_model.sv ----
`timescale 1ns/1ps
// controller side of the command word, written by ordinary word moves
module aiwc_host_model (
	// word chosen by the bench
	input wire logic [15:0] word_i,
	// command word to the unit
	output aiwc_pkg::aiwc_cmd_t cmd_o
);
	// moves cannot touch the transfer bits, so they always go out as zero
	assign cmd_o = aiwc_pkg::aiwc_cmd_t'({word_i[15:3], 3'h0});
endmodule

// ---- sim/test_analog_input_io_word_control.sv ----
`timescale 1ns/1ps
module test_analog_input_io_word_control;
	localparam int HALF = 4;
	logic mclk_i, rstn_i, xs, xw, xe, dinv, dval, cerr, alm, rng, ok, pkd, save, swen;
	logic [15:0] word, pkc;
	aiwc_pkg::aiwc_cmd_t cmd;
	aiwc_pkg::aiwc_status_t st;
	int fail_count = 0;
	int check_count = 0;
	int span;
	aiwc_host_model i_host (.word_i(word), .cmd_o(cmd));
	aiwc_top #(.HALF_CYCLES(HALF)) i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cmd_i(cmd), .xfer_start_i(xs),
		.xfer_is_write_i(xw), .xfer_end_i(xe), .status_o(st), .data_invalid_i(dinv), .data_valid_i(dval),
		.conv_err_i(cerr), .any_alarm_i(alm), .any_range_i(rng), .unit_ok_i(ok), .pk_done_i(pkd),
		.save_req_o(save), .serial_wen_o(swen), .pk_clear_o(pkc));
	// 50 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	// wait some rising edges; drives follow by non-blocking assignment
	task tk(input int c);
		repeat (c) @(posedge mclk_i);
	endtask
	// compare and count
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// ordinary word move from the host, applied just after an edge
	task move_word(input logic [15:0] w);
		tk(1);
		word <= w;
	endtask
	// one block transfer: start, two busy cycles, end, one done cycle
	task block_xfer(input logic wr);
		tk(1);
		xs <= 1'b1;
		xw <= wr;
		tk(1);
		xs <= 1'b0;
		#1 chk(st, 16'h0001);
		tk(1);
		xe <= 1'b1;
		tk(1);
		xe <= 1'b0;
		#1 chk(st, wr ? 16'h0004 : 16'h0002);
		tk(1);
		#1 chk(st, 16'h0000);
	endtask
	// single exit point of the run
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// watchdog, far beyond the hundred or fewer cycles the tests need
	initial begin
		#100000;
		fail_count++;
		report_and_stop;
	end
	// main sequence
	initial begin
		{rstn_i, xs, xw, xe, dinv, dval, cerr, alm, rng, ok, pkd} = '0;
		word = 16'h0000;
		tk(10);
		rstn_i <= 1'b1;
		#1 chk(st, 16'h0000);
		// block read then block write handshake
		block_xfer(1'b0);
		block_xfer(1'b1);
		$display("transfer test done");
		// transfer bits set in the chosen word must be masked by the host side
		move_word(16'h001F);
		tk(1);
		#1 chk({14'h0, save, swen}, 16'h0003);
		move_word(16'h0000);
		#1 chk({14'h0, save, swen}, 16'h0001);
		tk(1);
		#1 chk({14'h0, save, swen}, 16'h0000);
		$display("save and serial test done");
		// events are one cycle long; alarm, range and bad data flags must outlive them
		tk(1);
		{alm, rng, dinv, cerr} <= 4'hF;
		tk(1);
		{alm, rng, dinv, cerr} <= 4'h0;
		#1 chk(st, 16'h0078);
		move_word(16'h0060);
		dval <= 1'b1;
		#1 chk(st, 16'h0068);
		move_word(16'h0000);
		dval <= 1'b0;
		#1 chk(st, 16'h0000);
		// a clear that meets a new alarm in the same cycle loses
		move_word(16'h0020);
		alm <= 1'b1;
		tk(1);
		alm <= 1'b0;
		#1 chk(st, 16'h0020);
		move_word(16'h0000);
		#1 chk(st, 16'h0000);
		$display("flag test done");
		// lowest point of bank one, highest point of bank two
		for (int b = 0; b < 2; b++) begin
			move_word((b == 1) ? 16'h8080 : 16'h0100);
			tk(1);
			pkd <= 1'b1;
			#1 chk(pkc, (b == 1) ? 16'h8000 : 16'h0001);
			tk(1);
			pkd <= 1'b0;
			#1 chk(st, (b == 1) ? 16'h8000 : 16'h0100);
			move_word(16'h0000);
			#1 chk(pkc, 16'h0000);
			chk(st, (b == 1) ? 16'h8000 : 16'h0100);
			tk(1);
			#1 chk(st, 16'h0000);
		end
		$display("peak hold test done");
		// heartbeat: find a rise, then time one high and one low phase
		tk(1);
		ok <= 1'b1;
		for (span = 0; span < 20 && st.good !== 1'b1; span++) begin
			tk(1);
			#1;
		end
		for (span = 0; span < 20 && st.good === 1'b1; span++) begin
			tk(1);
			#1;
		end
		chk(16'(span), 16'(HALF));
		for (span = 0; span < 20 && st.good === 1'b0; span++) begin
			tk(1);
			#1;
		end
		chk(16'(span), 16'(HALF));
		// a unit that stops running cuts the high phase short
		tk(1);
		ok <= 1'b0;
		tk(2);
		#1 chk({15'h0, st.good}, 16'h0000);
		$display("heartbeat test done");
		report_and_stop;
	end
endmodule
